/* File: rtl/lintm_mode_ctrl.sv */
// mode sequencer, bus driver gating and wake detection of the transceiver
// assumes pins arrive unsynchronised and an Avalon-MM master on the same clock
//
// Local design decisions: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none

module lintm_mode_ctrl #(
    parameter int DOM_TICKS = lintm_pkg::DOM_TIMEOUT_TICKS,
    parameter int GUARD_TICKS = lintm_pkg::TXD_GUARD_TICKS,
    parameter int BUS_TICKS = lintm_pkg::BUS_FILT_TICKS,
    parameter int WAKE_TICKS = lintm_pkg::WAKE_FILT_TICKS
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic enableIn,
    input wire logic txdIn,
    output logic txdOut,
    output logic txdOe,
    output logic rxdOut,
    output logic rxdOe,
    input wire logic linIn,
    output logic linOut,
    output logic linOe,
    input wire logic local_wake_in,
    input wire logic overTempIn,
    input wire logic battery_supplyLow,
    input wire logic battery_supplyOk,
    output logic regulator_inhibit_out,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    import lintm_pkg::*;

    function automatic logic [CNT_W-1:0] satInc(input logic [CNT_W-1:0] v);
        return (v == {CNT_W{1'b1}}) ? v : v + {{(CNT_W-1){1'b0}}, 1'b1};
    endfunction : satInc

    localparam logic [CNT_W-1:0] DOM_LIM = CNT_W'(DOM_TICKS);
    localparam logic [CNT_W-1:0] GUARD_LIM = CNT_W'(GUARD_TICKS);
    localparam logic [CNT_W-1:0] BUS_LIM = CNT_W'(BUS_TICKS);
    localparam logic [CNT_W-1:0] WAKE_LIM = CNT_W'(WAKE_TICKS);
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

    lintm_pins_t pinRaw;
    lintm_pins_t sync1_r;
    lintm_pins_t sync2_r;
    lintm_pins_t sync3_r;
    lintm_pins_t pin_r;
    lintm_mode_t state_r;
    lintm_mode_t state_nxt;
    lintm_src_t src_r;
    lintm_src_t src_nxt;
    logic [TICK_W-1:0] tickCnt_r;
    logic tick_r;
    logic [CNT_W-1:0] txLowCnt_r;
    logic [CNT_W-1:0] txHighCnt_r;
    logic [CNT_W-1:0] busLowCnt_r;
    logic [CNT_W-1:0] wakeLowCnt_r;
    logic wakeArmed_r;
    logic gate_r;
    logic enPrev_r;
    logic [1:0] ctrl_r;
    logic busWake;
    logic localWake;
    logic enFall;
    logic domTimeout;

    assign pinRaw = '{enable: enableIn, txd: txdIn, lin: linIn, localWake: local_wake_in,
        overTemp: overTempIn, supplyLow: battery_supplyLow, supplyOk: battery_supplyOk};

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_r <= PINS_RESET;
            sync2_r <= PINS_RESET;
            sync3_r <= PINS_RESET;
        end else begin
            sync1_r <= pinRaw;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_r <= PINS_RESET;
        end else begin
            pin_r <= (sync2_r & sync3_r) | (pin_r & (sync2_r ^ sync3_r));
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tickCnt_r <= '0;
            tick_r <= 1'b0;
        end else begin
            tick_r <= (tickCnt_r == TICK_LAST);
            tickCnt_r <= (tickCnt_r == TICK_LAST) ? '0 : tickCnt_r + TICK_W'(1);
        end
    end

    assign domTimeout = (txLowCnt_r >= DOM_LIM);

    // bus wake on rising edge after long dominant
    assign busWake = (state_r == MODE_SLEEP) && pin_r.lin && (busLowCnt_r > BUS_LIM)
        && ctrl_r[CTRL_BUS_WAKE_EN_BIT] && !pin_r.supplyLow;
    // local wake after long low level
    assign localWake = (state_r == MODE_SLEEP) && wakeArmed_r && !pin_r.localWake
        && (wakeLowCnt_r > WAKE_LIM) && ctrl_r[CTRL_LOCAL_WAKE_EN_BIT] && !pin_r.supplyLow;
    assign enFall = enPrev_r && !pin_r.enable;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            enPrev_r <= 1'b0;
        end else begin
            enPrev_r <= pin_r.enable;
        end
    end

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            MODE_UNPOWERED: begin
                if (pin_r.supplyOk) begin
                    state_nxt = MODE_FAILSAFE;
                end
            end
            MODE_FAILSAFE: begin
                if (!pin_r.supplyOk) begin
                    state_nxt = MODE_UNPOWERED;
                end else if (pin_r.enable && !pin_r.supplyLow) begin
                    state_nxt = MODE_NORMAL;
                end else if (enFall && pin_r.txd) begin
                    state_nxt = MODE_SLEEP;
                end
            end
            MODE_NORMAL: begin
                if (!pin_r.supplyOk) begin
                    state_nxt = MODE_UNPOWERED;
                end else if (pin_r.supplyLow) begin
                    state_nxt = MODE_FAILSAFE;
                end else if (!pin_r.enable && pin_r.txd) begin
                    state_nxt = MODE_SLEEP;
                end
            end
            MODE_SLEEP: begin
                if (!pin_r.supplyOk) begin
                    state_nxt = MODE_UNPOWERED;
                end else if (busWake || localWake) begin
                    state_nxt = MODE_FAILSAFE;
                end
            end
        endcase
    end

    always_comb begin
        src_nxt = src_r;
        if (state_nxt == MODE_UNPOWERED) begin
            src_nxt = SRC_NONE;
        end else if (state_r != MODE_NORMAL && state_nxt == MODE_NORMAL) begin
            src_nxt = SRC_NONE;
        end else if (state_r == MODE_NORMAL && state_nxt == MODE_FAILSAFE) begin
            src_nxt = SRC_SUPLOW;
        end else if (state_nxt == MODE_FAILSAFE && busWake) begin
            src_nxt = SRC_BUS;
        end else if (state_nxt == MODE_FAILSAFE && localWake) begin
            src_nxt = SRC_LOCAL;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= MODE_FAILSAFE;
            src_r <= SRC_NONE;
        end else begin
            state_r <= state_nxt;
            src_r <= src_nxt;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            txLowCnt_r <= '0;
            txHighCnt_r <= '0;
        end else if (state_r != MODE_NORMAL) begin
            txLowCnt_r <= '0;
            txHighCnt_r <= '0;
        end else if (pin_r.txd) begin
            txLowCnt_r <= '0;
            txHighCnt_r <= tick_r ? satInc(txHighCnt_r) : txHighCnt_r;
        end else begin
            txHighCnt_r <= '0;
            txLowCnt_r <= tick_r ? satInc(txLowCnt_r) : txLowCnt_r;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            gate_r <= 1'b0;
        end else if (state_r != MODE_NORMAL) begin
            gate_r <= pin_r.txd;
        end else if (domTimeout) begin
            gate_r <= 1'b0;
        end else if (txHighCnt_r > GUARD_LIM) begin
            gate_r <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            busLowCnt_r <= '0;
        end else if (state_r != MODE_SLEEP || pin_r.lin) begin
            busLowCnt_r <= '0;
        end else if (tick_r) begin
            busLowCnt_r <= satInc(busLowCnt_r);
        end
    end

    // local wake filter, armed by a high level
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wakeArmed_r <= 1'b0;
            wakeLowCnt_r <= '0;
        end else if (state_r != MODE_SLEEP) begin
            wakeArmed_r <= 1'b0;
            wakeLowCnt_r <= '0;
        end else if (pin_r.localWake) begin
            wakeArmed_r <= 1'b1;
            wakeLowCnt_r <= '0;
        end else if (wakeArmed_r && tick_r) begin
            wakeLowCnt_r <= satInc(wakeLowCnt_r);
        end
    end

    // bus pin drivers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            linOe <= 1'b0;
            linOut <= 1'b0;
        end else begin
            linOut <= 1'b0;
            linOe <= (state_r == MODE_NORMAL) && gate_r && !pin_r.txd && !domTimeout
                && !pin_r.overTemp && !pin_r.supplyLow;
        end
    end

    // controller-side pins
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rxdOut <= 1'b1;
            rxdOe <= 1'b1;
            txdOut <= 1'b1;
            txdOe <= 1'b1;
        end else begin
            unique case (state_r)
                MODE_NORMAL: begin
                    rxdOut <= pin_r.lin;
                    rxdOe <= 1'b1;
                    txdOut <= 1'b0;
                    txdOe <= 1'b0;
                end
                MODE_FAILSAFE: begin
                    rxdOut <= src_r[0];
                    rxdOe <= 1'b1;
                    txdOut <= src_r[1];
                    txdOe <= 1'b1;
                end
                default: begin
                    rxdOut <= 1'b1;
                    rxdOe <= 1'b0;
                    txdOut <= 1'b0;
                    txdOe <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            regulator_inhibit_out <= 1'b1;
        end else begin
            regulator_inhibit_out <= (state_r == MODE_NORMAL) || (state_r == MODE_FAILSAFE);
        end
    end

    // avalon slave: one wait cycle per access
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= '0;
            ctrl_r <= CTRL_RESET;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
            if (avs_read && avs_waitrequest) begin
                avs_readdata <= '0;
                if (avs_address == ADDR_CTRL) begin
                    avs_readdata[1:0] <= ctrl_r;
                end else if (avs_address == ADDR_STATUS) begin
                    avs_readdata[STAT_MODE_LSB +: 4] <= state_r;
                    avs_readdata[STAT_SRC_LSB +: 2] <= src_r;
                    avs_readdata[STAT_GATE_BIT] <= gate_r;
                    avs_readdata[STAT_OVTEMP_BIT] <= pin_r.overTemp;
                    avs_readdata[STAT_SUPLOW_BIT] <= pin_r.supplyLow;
                    avs_readdata[STAT_LINDRV_BIT] <= linOe;
                end
            end
            if (avs_write && !avs_waitrequest && avs_address == ADDR_CTRL && avs_byteenable[0]) begin
                ctrl_r <= avs_writedata[1:0];
            end
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    property p_drvNormal;
        linOe |-> $past(state_r) == MODE_NORMAL && !$past(pin_r.txd);
    endproperty
    a_drvNormal: assert property (p_drvNormal) else $error("bus driven outside normal");

    property p_timeout;
        domTimeout |=> !linOe;
    endproperty
    a_timeout: assert property (p_timeout) else $error("driver on after time-out");

    property p_sleepEntry;
        state_r == MODE_NORMAL && pin_r.supplyOk && !pin_r.supplyLow && !pin_r.enable && pin_r.txd
            |=> state_r == MODE_SLEEP ##1 !regulator_inhibit_out;
    endproperty
    a_sleepEntry: assert property (p_sleepEntry) else $error("sleep entry or inhibit wrong");

    property p_srcClear;
        $rose(state_r == MODE_NORMAL) |-> src_r == SRC_NONE;
    endproperty
    a_srcClear: assert property (p_srcClear) else $error("stale source in normal");

    property p_rxdOff;
        state_r == MODE_UNPOWERED |=> !rxdOe;
    endproperty
    a_rxdOff: assert property (p_rxdOff) else $error("receive driven while unpowered");

    property p_mirror;
        state_r == MODE_NORMAL |=> rxdOe && rxdOut == $past(pin_r.lin);
    endproperty
    a_mirror: assert property (p_mirror) else $error("receive does not mirror bus");

    property p_fsExit;
        state_r == MODE_FAILSAFE && pin_r.supplyOk && pin_r.enable && !pin_r.supplyLow
            |=> state_r == MODE_NORMAL;
    endproperty
    a_fsExit: assert property (p_fsExit) else $error("fail-safe not left on enable");

    property p_entryGuard;
        $rose(state_r == MODE_NORMAL) && !pin_r.txd |=> !gate_r [*3];
    endproperty
    a_entryGuard: assert property (p_entryGuard) else $error("driver armed with transmit low");

    property p_fsCode;
        state_r == MODE_FAILSAFE |=> txdOe && {txdOut, rxdOut} == $past(src_r);
    endproperty
    a_fsCode: assert property (p_fsCode) else $error("fail-safe code wrong");

    property p_busWake;
        busWake |=> state_r == MODE_FAILSAFE && src_r == SRC_BUS ##1 regulator_inhibit_out;
    endproperty
    a_busWake: assert property (p_busWake) else $error("bus wake not taken");

    property p_hotOff;
        pin_r.overTemp |=> !linOe;
    endproperty
    a_hotOff: assert property (p_hotOff) else $error("driver on while hot");

    c_busWake: cover property (busWake);
    c_localWake: cover property (localWake);
    c_timeout: cover property (state_r == MODE_NORMAL && domTimeout);
    c_underVolt: cover property (state_r == MODE_NORMAL ##1 src_r == SRC_SUPLOW);

endmodule : lintm_mode_ctrl

`default_nettype wire

/* File: rtl/lintm_pkg.sv */
// constants, types and register map of the transceiver mode controller
// assumes a single 20 MHz clock and an async active-low power-up reset
package lintm_pkg;

    // time base
    localparam int CLK_PERIOD_NS = 50;
    localparam int TICK_NS = 1000;
    localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
    localparam int NS_PER_US = 1000;
    localparam int US_PER_MS = 1000;

    // durations in their own units
    localparam int DOM_TIMEOUT_MS = 20;
    localparam int TXD_GUARD_US = 10;
    localparam int BUS_FILT_US = 100;
    localparam int WAKE_FILT_US = 100;

    // durations in ticks
    localparam int DOM_TIMEOUT_TICKS = DOM_TIMEOUT_MS * US_PER_MS * NS_PER_US / TICK_NS;
    localparam int TXD_GUARD_TICKS = (TXD_GUARD_US * NS_PER_US + TICK_NS - 1) / TICK_NS;
    localparam int BUS_FILT_TICKS = (BUS_FILT_US * NS_PER_US + TICK_NS - 1) / TICK_NS;
    localparam int WAKE_FILT_TICKS = (WAKE_FILT_US * NS_PER_US + TICK_NS - 1) / TICK_NS;
    localparam int CNT_W = 16;
    localparam int TICK_W = 8;

    // register map, byte addresses
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam int CTRL_LOCAL_WAKE_EN_BIT = 0;
    localparam int CTRL_BUS_WAKE_EN_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h3;
    localparam int STAT_MODE_LSB = 0;
    localparam int STAT_SRC_LSB = 4;
    localparam int STAT_GATE_BIT = 6;
    localparam int STAT_OVTEMP_BIT = 7;
    localparam int STAT_SUPLOW_BIT = 8;
    localparam int STAT_LINDRV_BIT = 9;

    typedef enum logic [3:0] {
        MODE_UNPOWERED = 4'h1,
        MODE_FAILSAFE = 4'h2,
        MODE_NORMAL = 4'h4,
        MODE_SLEEP = 4'h8
    } lintm_mode_t;

    // bit 1 is the transmit pin level, bit 0 the receive pin level
    typedef enum logic [1:0] {
        SRC_BUS = 2'h0,
        SRC_LOCAL = 2'h1,
        SRC_SUPLOW = 2'h2,
        SRC_NONE = 2'h3
    } lintm_src_t;

    typedef struct packed {
        logic enable;
        logic txd;
        logic lin;
        logic localWake;
        logic overTemp;
        logic supplyLow;
        logic supplyOk;
    } lintm_pins_t;

    localparam lintm_pins_t PINS_RESET = '{
        enable: 1'b0, txd: 1'b1, lin: 1'b1, localWake: 1'b1,
        overTemp: 1'b0, supplyLow: 1'b0, supplyOk: 1'b1};

endpackage : lintm_pkg

/* File: tb/lintm_far_model.sv */
// far-side model: controller transmit drive, other bus nodes, line pull-ups
// assumes the bench commands the controller level and remote dominant
`timescale 1ns/10ps
`default_nettype none

module lintm_far_model (
    input wire logic ctlTxd,
    input wire logic nodeDom,
    input wire logic txdOut,
    input wire logic txdOe,
    input wire logic linOut,
    input wire logic linOe,
    input wire logic rxdOut,
    input wire logic rxdOe,
    output logic txdPin,
    output logic linPin,
    output logic rxdPin
);
    assign txdPin = txdOe ? txdOut : ctlTxd;
    assign linPin = !((linOe && !linOut) || nodeDom);
    assign rxdPin = !(rxdOe && !rxdOut);
endmodule : lintm_far_model

`default_nettype wire

/* File: tb/testbench.sv */
// self-checking bench of the transceiver mode controller
// assumes lintm_pkg, lintm_mode_ctrl and the far-side model are compiled first
`timescale 1ns/10ps
`default_nettype none

module testbench;
    import lintm_pkg::*;
    localparam int DOM = 50;
    localparam int GUARD = 3;
    localparam int FILT = 5;
    localparam int TK = TICK_CYCLES;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic enableIn = 1'b0;
    logic ctlTxd = 1'b1;
    logic nodeDom = 1'b0;
    logic localWake = 1'b1;
    logic overTempIn = 1'b0;
    logic supLow = 1'b0;
    logic supOk = 1'b1;
    logic [3:0] avsAddress = 4'h0;
    logic avsRead = 1'b0;
    logic avsWrite = 1'b0;
    logic [31:0] avsWritedata = 32'h0;
    logic [3:0] avsByteen = 4'hF;
    logic [31:0] avsReaddata;
    logic avsWaitrequest;
    logic txdOut, txdOe, rxdOut, rxdOe, linOut, linOe, inhOut, txdPin, linPin, rxdPin;
    logic [31:0] rd;
    int num_errors = 0;
    int cmp_count = 0;
    integer seed = 32'hB8761C71;

    always #25 clk = ~clk;

    lintm_mode_ctrl #(.DOM_TICKS(DOM), .GUARD_TICKS(GUARD), .BUS_TICKS(FILT), .WAKE_TICKS(FILT)) DUT (
        .clk(clk), .arst_n(arst_n), .enableIn(enableIn), .txdIn(txdPin), .txdOut(txdOut), .txdOe(txdOe),
        .rxdOut(rxdOut), .rxdOe(rxdOe), .linIn(linPin), .linOut(linOut), .linOe(linOe),
        .local_wake_in(localWake), .overTempIn(overTempIn), .battery_supplyLow(supLow),
        .battery_supplyOk(supOk), .regulator_inhibit_out(inhOut), .avs_address(avsAddress),
        .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWritedata), .avs_byteenable(avsByteen),
        .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest));

    lintm_far_model farEnd (
        .ctlTxd(ctlTxd), .nodeDom(nodeDom), .txdOut(txdOut), .txdOe(txdOe), .linOut(linOut),
        .linOe(linOe), .rxdOut(rxdOut), .rxdOe(rxdOe), .txdPin(txdPin), .linPin(linPin), .rxdPin(rxdPin));

    function automatic logic exp_lin(input logic t, input logic n);
        return t && !n;
    endfunction : exp_lin

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    // entered right after a rising edge; holds until waitrequest is sampled low at a rising edge
    task automatic av_xfer(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] d);
        int n;
        n = 0;
        avsAddress <= a;
        avsWritedata <= wd;
        avsRead <= !wr;
        avsWrite <= wr;
        @(posedge clk);
        while (avsWaitrequest !== 1'b0 && n < 50) begin
            @(posedge clk);
            n++;
        end
        d = avsReaddata;
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
        @(posedge clk);
        if (n >= 50) begin
            num_errors++;
            end_sim();
        end
    endtask : av_xfer

    task automatic rearm();
        ctlTxd <= 1'b1;
        cyc((GUARD + 3) * TK);
        ctlTxd <= 1'b0;
        cyc(8);
    endtask : rearm

    task automatic fs_check(input logic [1:0] code);
        chk("inhibit", inhOut, 1'b1);
        chk("txdOe", txdOe, 1'b1);
        chk("fsCode", {txdOut, rxdOut}, code);
    endtask : fs_check

    initial begin
        repeat (40000) @(posedge clk);
        num_errors++;
        end_sim();
    end

    initial begin
        cyc(6);
        arst_n <= 1'b1;
        cyc(2);
        fs_check(SRC_NONE);
        chk("linOe", linOe, 1'b0);
        av_xfer(1'b0, ADDR_CTRL, 32'h0, rd);
        chk("ctrl", rd, CTRL_RESET);
        av_xfer(1'b0, ADDR_STATUS, 32'h0, rd);
        chk("mode", rd[3:0], MODE_FAILSAFE);
        av_xfer(1'b1, 4'hC, 32'hFFFFFFFF, rd);
        av_xfer(1'b0, 4'hC, 32'h0, rd);
        chk("unmapped", rd, 32'h0);
        av_xfer(1'b1, ADDR_CTRL, 32'hFFFFFFFE, rd);
        av_xfer(1'b0, ADDR_CTRL, 32'h0, rd);
        chk("ctrlRw", rd, 32'h2);
        avsByteen <= 4'hE;
        av_xfer(1'b1, ADDR_CTRL, 32'h1, rd);
        avsByteen <= 4'hF;
        av_xfer(1'b0, ADDR_CTRL, 32'h0, rd);
        chk("ctrlLane", rd, 32'h2);
        av_xfer(1'b1, ADDR_CTRL, 32'h3, rd);
        enableIn <= 1'b1;
        cyc(10);
        chk("inhNormal", inhOut, 1'b1);
        chk("txdOeNormal", txdOe, 1'b0);
        for (int i = 0; i < 24; i++) begin
            ctlTxd <= 1'($random(seed));
            nodeDom <= (i == 5) ? 1'b1 : 1'($random(seed));
            cyc(12);
            chk("linOe", linOe, !ctlTxd);
            chk("linOut", linOut, 1'b0);
            chk("rxd", rxdOut, exp_lin(ctlTxd, nodeDom));
        end
        nodeDom <= 1'b0;
        ctlTxd <= 1'b0;
        cyc((DOM - 5) * TK);
        chk("linOeBefore", linOe, 1'b1);
        cyc(10 * TK);
        chk("linOeTimeout", linOe, 1'b0);
        ctlTxd <= 1'b1;
        cyc(2 * TK);
        ctlTxd <= 1'b0;
        cyc(8);
        chk("shortRearm", linOe, 1'b0);
        enableIn <= 1'b0;
        cyc(10);
        chk("noSleepTxdLow", inhOut, 1'b1);
        enableIn <= 1'b1;
        rearm();
        chk("rearm", linOe, 1'b1);
        ctlTxd <= 1'b1;
        enableIn <= 1'b0;
        cyc(10);
        chk("inhSleep", inhOut, 1'b0);
        chk("rxdOeSleep", rxdOe, 1'b0);
        ctlTxd <= 1'b0;
        cyc(10);
        chk("linOeSleep", linOe, 1'b0);
        ctlTxd <= 1'b1;
        localWake <= 1'b0;
        cyc((FILT + 3) * TK);
        fs_check(SRC_LOCAL);
        localWake <= 1'b1;
        ctlTxd <= 1'b0;
        enableIn <= 1'b1;
        cyc(10);
        chk("entryGuard", linOe, 1'b0);
        av_xfer(1'b0, ADDR_STATUS, 32'h0, rd);
        chk("srcCleared", rd[5:4], SRC_NONE);
        chk("modeNormal", rd[3:0], MODE_NORMAL);
        rearm();
        chk("entryArmed", linOe, 1'b1);
        ctlTxd <= 1'b1;
        enableIn <= 1'b0;
        cyc(10);
        nodeDom <= 1'b1;
        cyc(2 * TK);
        nodeDom <= 1'b0;
        cyc(10);
        chk("shortDom", inhOut, 1'b0);
        nodeDom <= 1'b1;
        cyc((FILT + 3) * TK);
        chk("heldShort", inhOut, 1'b0);
        nodeDom <= 1'b0;
        cyc(10);
        fs_check(SRC_BUS);
        enableIn <= 1'b1;
        rearm();
        overTempIn <= 1'b1;
        cyc(8);
        chk("overTemp", linOe, 1'b0);
        overTempIn <= 1'b0;
        cyc(8);
        chk("coolDown", linOe, 1'b1);
        supLow <= 1'b1;
        cyc(10);
        chk("supLow", linOe, 1'b0);
        fs_check(SRC_SUPLOW);
        ctlTxd <= 1'b1;
        enableIn <= 1'b0;
        cyc(10);
        chk("fsSleep", inhOut, 1'b0);
        supLow <= 1'b0;
        supOk <= 1'b0;
        cyc(10);
        chk("inhOff", inhOut, 1'b0);
        supOk <= 1'b1;
        cyc(10);
        chk("powerUp", inhOut, 1'b1);
        fs_check(SRC_NONE);
        enableIn <= 1'b1;
        cyc(10);
        chk("rxdOeNormal", rxdOe, 1'b1);
        supOk <= 1'b0;
        cyc(10);
        chk("rxdOeOff", rxdOe, 1'b0);
        end_sim();
    end
endmodule : testbench

`default_nettype wire
